/* design/bbie_defines.svh */
// constants for the byte and bit instruction execute block
// Behaviour
// (RULE1) Every program counter write other than the jump instruction forces counter bit eight low.
// (RULE2) A read-modify-write of the second I/O port takes its source from the pin levels, not the latch.
// (RULE3) load_direction_latch with file operand six copies the accumulator into the port direction latch.
// (RULE4) A direction latch bit of one floats its pin by turning that pin's output enable off.
// (RULE5) A file write to timer_counter_reg clears the prescaler when the prescaler belongs to the timer.
// (RULE6) add_accum_file sums accumulator and file register and updates carry, nibble carry and zero.
// (RULE7) For byte file instructions destination zero writes the accumulator and one writes the file register.
// (RULE8) bit_clear_file clears the selected bit of the file register and keeps all flags.
// (RULE9) bit_set_file sets the selected bit of the file register and keeps all flags.
// (RULE10) and_literal_accum ANDs the accumulator with an eight-bit literal and updates only zero.
// (RULE11) and_accum_file ANDs accumulator and file register into the chosen destination, zero only.
// (RULE12) test_skip_if_zero on a clear bit flushes the fetched instruction and runs an idle_slot.
// (RULE13) test_skip_if_one on a set bit flushes the fetched instruction and runs an idle_slot, no flags.
// (RULE14) Bit instructions decode from the top four opcode bits, then bit index and file address.
// (RULE15) Zero follows an all-zero result; add sets carry from bit seven and nibble carry from bit three.
`ifndef BBIE_DEFINES_SVH
`define BBIE_DEFINES_SVH

`define BBIE_INSTR_W     12
`define BBIE_DATA_W      8
`define BBIE_ADDR_W      5
`define BBIE_PC_W        9
`define BBIE_BIT_W       3

`define BBIE_OP6_ADD     6'h07
`define BBIE_OP6_ANDF    6'h05
`define BBIE_OP4_ANDL    4'hE
`define BBIE_OP4_BCLR    4'h4
`define BBIE_OP4_BSET    4'h5
`define BBIE_OP4_TSTZ    4'h6
`define BBIE_OP4_TSTO    4'h7
`define BBIE_OP3_JUMP    3'h5
`define BBIE_DIR_LOAD    12'h006

`define BBIE_ADDR_TIMER  5'h01
`define BBIE_ADDR_PCLOW  5'h02
`define BBIE_ADDR_PORT   5'h06

`define BBIE_ACC_RST     8'h00
`define BBIE_DIR_RST     8'hFF
`define BBIE_OE_RST      8'h00

`endif

/* design/bbie_pkg.sv */
// types shared by the execute block
`include "bbie_defines.svh"
package bbie_pkg;
    typedef enum logic [1:0] {PH_IDLE, PH_EXEC, PH_SKIP} bbie_phase_t;

    typedef enum logic [2:0] {ALU_PASS, ALU_ADD, ALU_AND, ALU_CLR, ALU_SET} bbie_alu_op_t;

    typedef struct packed {
        logic carry;
        logic nibbleOverflowFlag;
        logic zero;
    } bbie_flags_t;

    typedef struct packed {
        bbie_phase_t                 phase;
        logic [`BBIE_INSTR_W-1:0]    instr;
        logic [`BBIE_DATA_W-1:0]     accum;
        bbie_flags_t                 flags;
        logic [`BBIE_DATA_W-1:0]     dirLatch;
        logic [`BBIE_DATA_W-1:0]     portOutEn;
        logic [`BBIE_ADDR_W-1:0]     fileAddr;
        logic                        fileWrEn;
        logic [`BBIE_DATA_W-1:0]     fileWrData;
        logic                        pcLoad;
        logic [`BBIE_PC_W-1:0]       pcLoadValue;
        logic                        fetchFlush;
        logic                        prescClear;
        logic                        ready;
        logic                        execDone;
    } bbie_state_t;
endpackage

/* design/bbie_alu.sv */
// combinational arithmetic and bit logic with flag generation
`timescale 1ns/1ps
`include "bbie_defines.svh"
module bbie_alu #(
    parameter int W = `BBIE_DATA_W
) (
    input  wire logic                        [W-1:0]  accum,
    input  wire logic                        [W-1:0]  operand,
    input  wire logic           [`BBIE_BIT_W-1:0]     bitIdx,
    input  wire bbie_pkg::bbie_alu_op_t               op,
    output logic                             [W-1:0]  result,
    output logic                                      carryOut,
    output logic                                      nibbleOut,
    output logic                                      zeroOut
);
    if (W != `BBIE_DATA_W) begin : g_width_check
        $error("bbie_alu supports only the eight-bit data width");
    end

    function automatic logic allZero(input logic [W-1:0] v);
        allZero = (v == '0);
    endfunction

    logic [W:0] sum;
    logic [4:0] lowSum;
    logic [W-1:0] mask;

    always_comb begin
        // (RULE6) full sum of accumulator and file
        sum      = {1'h0, accum} + {1'h0, operand};
        lowSum   = {1'h0, accum[3:0]} + {1'h0, operand[3:0]};
        mask     = W'(1) << bitIdx;
        result   = operand;
        carryOut = 1'h0;
        nibbleOut = 1'h0;
        case (op)
            bbie_pkg::ALU_ADD: begin
                result = sum[W-1:0];
                // (RULE15) carry from bit seven and bit three
                carryOut  = sum[W];
                nibbleOut = lowSum[4];
            end
            bbie_pkg::ALU_AND: result = accum & operand;
            bbie_pkg::ALU_CLR: result = operand & ~mask;
            bbie_pkg::ALU_SET: result = operand | mask;
            default: result = operand;
        endcase
        // (RULE15) zero on an all-zero result
        zeroOut = allZero(result);
    end
endmodule

/* design/bbie_exec_core.sv */
// execute stage for byte, bit, literal-AND and direction latch instructions
`timescale 1ns/1ps
`include "bbie_defines.svh"
module bbie_exec_core #(
    parameter int DATA_W = `BBIE_DATA_W
) (
    input  wire logic                                ref_clk,
    input  wire logic                                sys_rst,
    input  wire logic                                instrValid,
    input  wire logic        [`BBIE_INSTR_W-1:0]     instrWord,
    input  wire logic        [`BBIE_DATA_W-1:0]      fileRdData,
    input  wire logic        [`BBIE_DATA_W-1:0]      portPinLevel,
    input  wire logic                                prescAssigned,
    output logic                                     instrReady,
    output logic                                     execDone,
    output logic             [`BBIE_ADDR_W-1:0]      fileAddr,
    output logic                                     fileWrEn,
    output logic             [`BBIE_DATA_W-1:0]      fileWrData,
    output logic             [`BBIE_DATA_W-1:0]      accum,
    output bbie_pkg::bbie_flags_t                    statusFlags,
    output logic                                     pcLoad,
    output logic             [`BBIE_PC_W-1:0]        pcLoadValue,
    output logic                                     fetchFlush,
    output logic                                     prescClear,
    output logic             [`BBIE_DATA_W-1:0]      dirLatch,
    output logic             [`BBIE_DATA_W-1:0]      portOutEn
);
    if (DATA_W != `BBIE_DATA_W) begin : g_width_check
        $error("bbie_exec_core supports only the eight-bit data width");
    end

    localparam bbie_pkg::bbie_state_t RST_ST = '{
        phase:       bbie_pkg::PH_IDLE,
        instr:       '0,
        accum:       `BBIE_ACC_RST,
        flags:       '0,
        dirLatch:    `BBIE_DIR_RST,
        portOutEn:   `BBIE_OE_RST,
        fileAddr:    '0,
        fileWrEn:    1'h0,
        fileWrData:  '0,
        pcLoad:      1'h0,
        pcLoadValue: '0,
        fetchFlush:  1'h0,
        prescClear:  1'h0,
        ready:       1'h1,
        execDone:    1'h0
    };

    bbie_pkg::bbie_state_t              st;
    bbie_pkg::bbie_state_t              next_st;
    bbie_pkg::bbie_alu_op_t             aluOp;
    logic [`BBIE_DATA_W-1:0]            srcVal;
    logic [`BBIE_DATA_W-1:0]            aluIn;
    logic [`BBIE_DATA_W-1:0]            aluRes;
    logic                               aluCarry;
    logic                               aluNibble;
    logic                               aluZero;
    logic [`BBIE_ADDR_W-1:0]            fAddr;
    logic [`BBIE_BIT_W-1:0]             bitIdx;
    logic                               dBit;
    logic                               isAdd;
    logic                               isAndF;
    logic                               isAndL;
    logic                               isBclr;
    logic                               isBset;
    logic                               isTstZ;
    logic                               isTstO;
    logic                               isJump;
    logic                               isDirLoad;
    logic                               wrFile;
    logic                               testBit;
    logic [4:0]                         nibSum;

    // (RULE14) opcode fields
    assign fAddr     = st.instr[4:0];
    assign bitIdx    = st.instr[7:5];
    assign dBit      = st.instr[5];
    assign isAdd     = st.instr[11:6] == `BBIE_OP6_ADD;
    assign isAndF    = st.instr[11:6] == `BBIE_OP6_ANDF;
    assign isAndL    = st.instr[11:8] == `BBIE_OP4_ANDL;
    assign isBclr    = st.instr[11:8] == `BBIE_OP4_BCLR;
    assign isBset    = st.instr[11:8] == `BBIE_OP4_BSET;
    assign isTstZ    = st.instr[11:8] == `BBIE_OP4_TSTZ;
    assign isTstO    = st.instr[11:8] == `BBIE_OP4_TSTO;
    assign isJump    = st.instr[11:9] == `BBIE_OP3_JUMP;
    assign isDirLoad = st.instr == `BBIE_DIR_LOAD;
    // (RULE7) destination one sends byte results to the file
    assign wrFile    = ((isAdd || isAndF) && dBit) || isBclr || isBset;

    // (RULE2) port reads see the pins, not the output latch
    assign srcVal  = (fAddr == `BBIE_ADDR_PORT) ? portPinLevel : fileRdData;
    assign aluIn   = isAndL ? st.instr[7:0] : srcVal;
    assign testBit = srcVal[bitIdx];
    assign nibSum  = {1'h0, st.accum[3:0]} + {1'h0, srcVal[3:0]};

    always_comb begin
        if (isAdd) aluOp = bbie_pkg::ALU_ADD;
        else if (isAndF || isAndL) aluOp = bbie_pkg::ALU_AND;
        else if (isBclr) aluOp = bbie_pkg::ALU_CLR;
        else if (isBset) aluOp = bbie_pkg::ALU_SET;
        else aluOp = bbie_pkg::ALU_PASS;
    end

    bbie_alu #(.W(`BBIE_DATA_W)) u_alu (
        .accum     (st.accum),
        .operand   (aluIn),
        .bitIdx    (bitIdx),
        .op        (aluOp),
        .result    (aluRes),
        .carryOut  (aluCarry),
        .nibbleOut (aluNibble),
        .zeroOut   (aluZero)
    );

    always_comb begin
        next_st            = st;
        next_st.fileWrEn   = 1'h0;
        next_st.pcLoad     = 1'h0;
        next_st.fetchFlush = 1'h0;
        next_st.prescClear = 1'h0;
        next_st.execDone   = 1'h0;
        case (st.phase)
            bbie_pkg::PH_IDLE: begin
                if (instrValid) begin
                    next_st.instr    = instrWord;
                    next_st.fileAddr = instrWord[4:0];
                    next_st.ready    = 1'h0;
                    next_st.phase    = bbie_pkg::PH_EXEC;
                end
            end
            bbie_pkg::PH_EXEC: begin
                next_st.execDone = 1'h1;
                next_st.ready    = 1'h1;
                next_st.phase    = bbie_pkg::PH_IDLE;
                // (RULE6) add updates all three flags
                if (isAdd) begin
                    next_st.flags = '{carry: aluCarry, nibbleOverflowFlag: aluNibble,
                                      zero: aluZero};
                end
                // (RULE10) (RULE11) AND forms touch zero only
                if (isAndF || isAndL) begin
                    next_st.flags.zero = aluZero;
                end
                // (RULE7) destination zero loads the accumulator
                if (((isAdd || isAndF) && !dBit) || isAndL) begin
                    next_st.accum = aluRes;
                end
                // (RULE8) (RULE9) bit writes keep flags
                if (wrFile) begin
                    next_st.fileWrEn   = 1'h1;
                    next_st.fileWrData = aluRes;
                end
                // (RULE1) counter low writes clear bit eight
                if (wrFile && fAddr == `BBIE_ADDR_PCLOW) begin
                    next_st.pcLoad      = 1'h1;
                    next_st.pcLoadValue = {1'h0, aluRes};
                end
                // jump is the one writer that keeps bit eight
                if (isJump) begin
                    next_st.pcLoad      = 1'h1;
                    next_st.pcLoadValue = st.instr[8:0];
                end
                // (RULE5) timer write clears its prescaler
                if (wrFile && fAddr == `BBIE_ADDR_TIMER && prescAssigned) begin
                    next_st.prescClear = 1'h1;
                end
                // (RULE3) (RULE4) direction latch and output enables
                if (isDirLoad) begin
                    next_st.dirLatch  = st.accum;
                    next_st.portOutEn = ~st.accum;
                end
                // (RULE12) (RULE13) skip turns next slot idle
                if ((isTstZ && !testBit) || (isTstO && testBit)) begin
                    next_st.fetchFlush = 1'h1;
                    next_st.ready      = 1'h0;
                    next_st.phase      = bbie_pkg::PH_SKIP;
                end
            end
            bbie_pkg::PH_SKIP: begin
                next_st.ready = 1'h1;
                next_st.phase = bbie_pkg::PH_IDLE;
            end
            default: next_st = RST_ST;
        endcase
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st <= RST_ST;
        end else begin
            st <= next_st;
        end
    end

    assign instrReady  = st.ready;
    assign execDone    = st.execDone;
    assign fileAddr    = st.fileAddr;
    assign fileWrEn    = st.fileWrEn;
    assign fileWrData  = st.fileWrData;
    assign accum       = st.accum;
    assign statusFlags = st.flags;
    assign pcLoad      = st.pcLoad;
    assign pcLoadValue = st.pcLoadValue;
    assign fetchFlush  = st.fetchFlush;
    assign prescClear  = st.prescClear;
    assign dirLatch    = st.dirLatch;
    assign portOutEn   = st.portOutEn;

    a_pc_bit_low: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE1
        (st.phase == bbie_pkg::PH_EXEC && wrFile && fAddr == `BBIE_ADDR_PCLOW)
        |=> pcLoad && !pcLoadValue[8] && pcLoadValue[7:0] == fileWrData)
        else $error("counter write kept bit eight");

    a_port_pin_source: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE2
        (st.phase == bbie_pkg::PH_EXEC && isAndF && !dBit && fAddr == `BBIE_ADDR_PORT)
        |=> accum == ($past(st.accum) & $past(portPinLevel)))
        else $error("port source not taken from pins");

    a_dir_latch_load: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE3
        (st.phase == bbie_pkg::PH_EXEC && isDirLoad) |=> dirLatch == $past(st.accum))
        else $error("direction latch not loaded from accumulator");

    a_pin_float: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE4
        (portOutEn & dirLatch) == '0)
        else $error("floating pin still has output enabled");

    a_presc_clear: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE5
        (st.phase == bbie_pkg::PH_EXEC && wrFile && fAddr == `BBIE_ADDR_TIMER && prescAssigned)
        |=> prescClear && fileWrEn ##1 !prescClear)
        else $error("prescaler clear missing or stretched");

    a_add_sum: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE6
        (st.phase == bbie_pkg::PH_EXEC && isAdd && !dBit)
        |=> {statusFlags.carry, accum} == 9'($past(st.accum)) + 9'($past(srcVal))
            && statusFlags.nibbleOverflowFlag == $past(nibSum[4])
            && statusFlags.zero == (accum == '0))
        else $error("add result or flags wrong");

    a_dest_file: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE7
        (st.phase == bbie_pkg::PH_EXEC && (isAdd || isAndF) && dBit)
        |=> fileWrEn && $stable(accum))
        else $error("destination one did not write the file");

    a_bit_clear: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE8
        (st.phase == bbie_pkg::PH_EXEC && isBclr)
        |=> fileWrEn && !fileWrData[$past(bitIdx)] && $stable(statusFlags))
        else $error("bit clear wrong");

    a_bit_set: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE9
        (st.phase == bbie_pkg::PH_EXEC && isBset)
        |=> fileWrEn && fileWrData == ($past(srcVal) | (8'h01 << $past(bitIdx)))
            && $stable(statusFlags))
        else $error("bit set wrong");

    a_and_literal: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE10
        (st.phase == bbie_pkg::PH_EXEC && isAndL)
        |=> accum == ($past(st.accum) & $past(st.instr[7:0]))
            && statusFlags.carry == $past(st.flags.carry)
            && statusFlags.zero == (accum == '0) && !fileWrEn)
        else $error("literal AND wrong");

    a_and_file: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE11
        (st.phase == bbie_pkg::PH_EXEC && isAndF && dBit)
        |=> fileWrData == ($past(st.accum) & $past(srcVal))
            && statusFlags.nibbleOverflowFlag == $past(st.flags.nibbleOverflowFlag))
        else $error("file AND wrong");

    a_skip_clear: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE12
        (st.phase == bbie_pkg::PH_EXEC && isTstZ && !testBit)
        |=> fetchFlush && !instrReady ##1 instrReady && !fetchFlush)
        else $error("skip on clear bit wrong");

    a_skip_set: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE13
        (st.phase == bbie_pkg::PH_EXEC && isTstO && testBit)
        |=> fetchFlush && $stable(statusFlags) ##1 instrReady)
        else $error("skip on set bit wrong");

    a_bit_decode: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE14
        (st.phase == bbie_pkg::PH_EXEC && isTstZ && testBit) |=> !fetchFlush && instrReady)
        else $error("test without skip stalled");
endmodule

/* sim/test_byte_bit_instruction_execute.sv */
// self-checking testbench for the byte and bit instruction execute block
`timescale 1ns/1ps
`include "bbie_defines.svh"
module test_byte_bit_instruction_execute;
    logic                  ref_clk;
    logic                  sys_rst;
    logic                  instrValid;
    logic [11:0]           instrWord;
    logic [7:0]            fileRdData;
    logic [7:0]            portPinLevel;
    logic                  prescAssigned;
    logic                  instrReady;
    logic                  execDone;
    logic [4:0]            fileAddr;
    logic                  fileWrEn;
    logic [7:0]            fileWrData;
    logic [7:0]            accum;
    bbie_pkg::bbie_flags_t statusFlags;
    logic                  pcLoad;
    logic [8:0]            pcLoadValue;
    logic                  fetchFlush;
    logic                  prescClear;
    logic [7:0]            dirLatch;
    logic [7:0]            portOutEn;
    int                    fails;
    int                    check_count;
    logic                  wr;
    logic                  pl;
    logic                  ff;
    logic                  pc;
    logic                  r2;
    logic                  r3;

    bbie_exec_core i_dut (
        .ref_clk       (ref_clk),
        .sys_rst       (sys_rst),
        .instrValid    (instrValid),
        .instrWord     (instrWord),
        .fileRdData    (fileRdData),
        .portPinLevel  (portPinLevel),
        .prescAssigned (prescAssigned),
        .instrReady    (instrReady),
        .execDone      (execDone),
        .fileAddr      (fileAddr),
        .fileWrEn      (fileWrEn),
        .fileWrData    (fileWrData),
        .accum         (accum),
        .statusFlags   (statusFlags),
        .pcLoad        (pcLoad),
        .pcLoadValue   (pcLoadValue),
        .fetchFlush    (fetchFlush),
        .prescClear    (prescClear),
        .dirLatch      (dirLatch),
        .portOutEn     (portOutEn)
    );

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // one instruction: offer, wait for acceptance, capture cycles two and three
    task automatic run(input logic [11:0] iw, input logic [7:0] rd, input logic [7:0] pins);
        int n;
        n = 0;
        @(negedge ref_clk);
        instrValid   = 1'b1;
        instrWord    = iw;
        fileRdData   = rd;
        portPinLevel = pins;
        while (instrReady !== 1'b1 && n < 10) begin
            @(negedge ref_clk);
            n++;
        end
        if (n >= 10) fails++;
        @(negedge ref_clk);
        instrValid = 1'b0;
        chk(16'(fileAddr), 16'(iw[4:0])); // address field
        @(negedge ref_clk);
        chk(16'(execDone), 16'h0001); // done pulse
        wr = fileWrEn;
        pl = pcLoad;
        ff = fetchFlush;
        pc = prescClear;
        r2 = instrReady;
        @(negedge ref_clk);
        r3 = instrReady;
        chk(16'({execDone, fileWrEn, fetchFlush}), 16'h0000); // one-cycle pulses
    endtask

    task automatic t_reset();
        chk(16'({instrReady, accum}), 16'h0100); // ready, accumulator reset
        chk(16'({dirLatch, portOutEn}), 16'hFF00); // pins float after reset
        chk(16'(statusFlags), 16'h0000); // flags cleared
        $display("test reset done");
    endtask

    task automatic t_add();
        prescAssigned = 1'b1;
        run({`BBIE_OP6_ADD, 1'b0, 5'h03}, 8'h8F, 8'h00);
        chk(16'({wr, accum}), 16'h008F); // destination accumulator
        chk(16'(statusFlags), 16'h0000); // no carry no zero
        run({`BBIE_OP6_ADD, 1'b1, `BBIE_ADDR_TIMER}, 8'h71, 8'h00);
        chk(16'({wr, fileWrData}), 16'h0100); // sum written back
        chk(16'(accum), 16'h008F); // accumulator kept
        chk(16'(statusFlags), 16'h0007); // carry nibble zero
        chk(16'(pc), 16'h0001); // prescaler cleared
        run({`BBIE_OP6_ADD, 1'b0, `BBIE_ADDR_TIMER}, 8'h01, 8'h00);
        chk(16'({pc, wr, accum}), 16'h0090); // no clear when d is zero
        chk(16'(statusFlags), 16'h0002); // nibble carry only
        $display("test add done");
    endtask

    task automatic t_and();
        run({`BBIE_OP4_ANDL, 8'hF0}, 8'h00, 8'h00);
        chk(16'({accum, statusFlags}), 16'({8'h90, 3'b010})); // zero only
        run({`BBIE_OP4_ANDL, 8'h0F}, 8'h00, 8'h00);
        chk(16'({accum, statusFlags}), 16'({8'h00, 3'b011})); // zero set
        run({`BBIE_OP6_ADD, 1'b0, 5'h04}, 8'h3C, 8'h00);
        run({`BBIE_OP6_ANDF, 1'b1, 5'h05}, 8'h0F, 8'h00);
        chk(16'({wr, fileWrData}), 16'h010C); // to file register
        chk(16'(accum), 16'h003C); // accumulator kept
        chk(16'(statusFlags), 16'h0000); // zero cleared
        run({`BBIE_OP6_ANDF, 1'b0, 5'h05}, 8'hC3, 8'h00);
        chk(16'({wr, accum, statusFlags}), 16'({1'b0, 8'h00, 3'b001})); // to accumulator
        $display("test and done");
    endtask

    task automatic t_bits();
        logic [2:0] fl;
        fl = statusFlags;
        for (int b = 0; b < 8; b++) begin
            run({`BBIE_OP4_BCLR, 3'(b), 5'h09}, 8'hFF, 8'h00);
            chk(16'({wr, fileWrData}), 16'({1'b1, ~(8'h01 << b)})); // bit cleared
            chk(16'(statusFlags), 16'(fl)); // flags kept
            run({`BBIE_OP4_BSET, 3'(b), 5'h0A}, 8'h00, 8'h00);
            chk(16'({wr, fileWrData}), 16'({1'b1, 8'h01 << b})); // bit set
            chk(16'(statusFlags), 16'(fl)); // flags kept
        end
        run({`BBIE_OP4_BSET, 3'h0, `BBIE_ADDR_TIMER}, 8'h00, 8'h00);
        chk(16'(pc), 16'h0001); // bit write to timer
        prescAssigned = 1'b0;
        run({`BBIE_OP4_BSET, 3'h0, `BBIE_ADDR_TIMER}, 8'h00, 8'h00);
        chk(16'(pc), 16'h0000); // prescaler not assigned
        $display("test bits done");
    endtask

    task automatic t_skip();
        logic [2:0] fl;
        logic       skip;
        fl = statusFlags;
        for (int k = 0; k < 4; k++) begin
            skip = (k[1] == 1'b0) ? ~k[0] : k[0];
            run({k[1] ? `BBIE_OP4_TSTO : `BBIE_OP4_TSTZ, 3'h5, 5'h0B},
                k[0] ? 8'h20 : 8'hDF, 8'h00);
            chk(16'({ff, r2, r3, wr}), 16'({skip, ~skip, 1'b1, 1'b0})); // flush, two cycles
            chk(16'(statusFlags), 16'(fl)); // flags kept
        end
        $display("test skip done");
    endtask

    task automatic t_port();
        run({`BBIE_OP4_BSET, 3'h7, `BBIE_ADDR_PORT}, 8'hFF, 8'h0F);
        chk(16'(fileWrData), 16'h008F); // pin levels used
        run({`BBIE_OP6_ADD, 1'b0, 5'h03}, 8'hA5, 8'h00);
        run(`BBIE_DIR_LOAD, 8'h00, 8'h00);
        chk(16'({dirLatch, portOutEn}), 16'hA55A); // accumulator to latch
        chk(16'(portOutEn & dirLatch), 16'h0000); // floating bits undriven
        run(12'h005, 8'h00, 8'h00);
        chk(16'({dirLatch, wr}), 16'h014A); // other operand ignored
        run({`BBIE_OP6_ANDF, 1'b0, `BBIE_ADDR_PORT}, 8'hFF, 8'h3C);
        chk(16'(accum), 16'h0024); // pins, not latch, feed the AND
        $display("test port done");
    endtask

    task automatic t_pc();
        run({`BBIE_OP4_BSET, 3'h7, `BBIE_ADDR_PCLOW}, 8'h7F, 8'h00);
        chk(16'({pl, pcLoadValue}), 16'h02FF); // bit eight forced low
        run({`BBIE_OP6_ADD, 1'b1, `BBIE_ADDR_PCLOW}, 8'h10, 8'h00);
        chk(16'({pl, pcLoadValue}), 16'h0234); // add into counter
        run({`BBIE_OP3_JUMP, 9'h1AB}, 8'h00, 8'h00);
        chk(16'({pl, pcLoadValue}), 16'h03AB); // jump keeps bit eight
        $display("test pc done");
    endtask

    // reset again in mid-run: every state returns to its reset value
    task automatic t_midreset();
        sys_rst = 1'b1;
        @(negedge ref_clk);
        sys_rst = 1'b0;
        t_reset();
    endtask

    initial begin
        fails         = 0;
        check_count   = 0;
        sys_rst       = 1'b1;
        instrValid    = 1'b0;
        instrWord     = 12'h000;
        fileRdData    = 8'h00;
        portPinLevel  = 8'h00;
        prescAssigned = 1'b0;
        repeat (16) @(negedge ref_clk);
        sys_rst = 1'b0;
        t_reset();
        t_add();
        t_and();
        t_bits();
        t_skip();
        t_port();
        t_pc();
        t_midreset();
        give_verdict();
    end

    initial begin
        #200000;
        fails++;
        give_verdict();
    end
endmodule
